// [rtl/phy_sap_message_framer.sv]
/*
 * PHY SAP message framer: emits timing indications every TTI, parses MAC
 * requests and answers those with confirm mode CONFIRM_STD with confirms; AXI4-Lite control registers.
 * Assumes a 200 MHz core_clk, MAC stream on core_clk, sync pin asynchronous.
 */
// Chosen here: the AXI4-Lite register port and the address map.
`include "phy_sap_params.svh"

module phy_sap_message_framer
    import phy_sap_pkg::*;
#(
    parameter int TTI_CYCLES = `TTI_TIME_US * `CLK_FREQ_MHZ
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] req_data,
    input  wire logic        req_valid,
    input  wire logic        req_last,
    output logic             req_ready,
    output logic [31:0]      msg_data,
    output logic             msg_valid,
    output logic             msg_last,
    input  wire logic        msg_ready,
    input  wire logic        dl_sync_ok
);
    function automatic logic [31:0] hdr_word(input msg_hdr_t h, input logic [1:0] idx);
        logic [127:0] flat;
        flat = h;
        hdr_word = flat[127 - 32 * idx -: 32];
    endfunction : hdr_word

    // Register bus
    logic [1:0]  ctrl;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [15:0] cnf_total;

    wire aw_take   = s_axi_awvalid && s_axi_awready;
    wire w_take    = s_axi_wvalid && s_axi_wready;
    wire wr_do     = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl   = wr_do && (aw_addr == `REG_CTRL);
    wire wr_mapped = (aw_addr == `REG_CTRL) || (aw_addr == `REG_STATUS) || (aw_addr == `REG_COUNT);
    wire ar_take   = s_axi_arvalid && s_axi_arready;

    // Timer and synchroniser
    logic [2:0] sync_ff;
    logic       sync_lvl;
    logic       tti_start;
    logic [9:0] sfn;
    logic [3:0] tti;

    wire sync_agree = (sync_ff[1] == sync_ff[2]);
    wire sync_rise  = sync_agree && sync_ff[2] && !sync_lvl;
    wire terminal   = ctrl[`CTRL_TERMINAL];
    wire resync     = terminal && sync_rise;
    wire run        = ctrl[`CTRL_ENABLE] && (!terminal || sync_lvl);

    // Statuses read back; frame counter is read-only
    wire [31:0] status_word = {6'h00, sfn, 4'h0, tti, 7'h00, sync_lvl};
    logic [15:0] tim_ref;
    wire [31:0] count_word  = {tim_ref, cnf_total};
    wire        rd_mapped   = (s_axi_araddr == `REG_CTRL) || (s_axi_araddr == `REG_STATUS)
                              || (s_axi_araddr == `REG_COUNT);
    wire [31:0] rd_word     = (s_axi_araddr == `REG_CTRL)   ? {30'h0, ctrl} :
                              (s_axi_araddr == `REG_STATUS) ? status_word :
                              (s_axi_araddr == `REG_COUNT)  ? count_word : 32'h0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            ctrl          <= `CTRL_RESET;
        end else begin
            if (aw_take) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                if (wr_ctrl && w_strb[0]) begin
                    ctrl <= w_data[1:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff  <= '0;
            sync_lvl <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[1:0], dl_sync_ok};
            if (sync_agree) begin
                sync_lvl <= sync_ff[2];
            end
        end
    end

    tti_timer #(
        .TTI_CYCLES (TTI_CYCLES)
    ) u_tti_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .run       (run),
        .resync    (resync),
        .tti_start (tti_start),
        .sfn       (sfn),
        .tti       (tti)
    );

    // Request parser
    logic [2:0]  in_idx;
    msg_id_t     req_id;
    logic [15:0] req_ref;
    logic [15:0] req_sfn;
    logic [7:0]  req_tti;
    logic [7:0]  req_cm;
    logic        cnf_pend;
    msg_hdr_t    cnf_hdr;

    wire       in_beat  = req_valid && req_ready;
    wire [7:0] cm_now   = (in_idx == 3'h3) ? req_data[31:24] : req_cm;
    wire       is_req   = (req_id.msg_class == `CLASS_REQ);
    wire       full_hdr = (in_idx >= 3'h3);
    wire       cnf_set  = in_beat && req_last && full_hdr && is_req && (cm_now == `CONFIRM_STD);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_idx  <= '0;
            req_id  <= '0;
            req_ref <= '0;
            req_sfn <= '0;
            req_tti <= '0;
            req_cm  <= '0;
        end else if (in_beat) begin
            in_idx <= req_last ? 3'h0 : (full_hdr ? `MSG_WORDS : in_idx + 3'h1);
            case (in_idx)
                3'h0: begin
                    req_id  <= req_data[31:16];
                    req_ref <= req_data[15:0];
                end
                3'h2: begin
                    req_sfn <= req_data[31:16];
                    req_tti <= req_data[15:8];
                end
                3'h3: req_cm <= req_data[31:24];
                default: ;
            endcase
        end
    end

    // Output framer
    out_state_t  state;
    logic [1:0]  out_idx;
    msg_hdr_t    out_hdr;
    logic        tim_pend;
    logic [9:0]  tim_sfn;
    logic [3:0]  tim_tti;
    msg_hdr_t    tim_hdr;

    wire load      = !msg_valid || msg_ready;
    wire start_tim = load && (state == ST_IDLE) && tim_pend;
    wire start_cnf = load && (state == ST_IDLE) && !tim_pend && cnf_pend;
    wire next_cnf_pend = cnf_set || (cnf_pend && !start_cnf);
    wire out_end   = load && (state != ST_IDLE) && (out_idx == `LAST_WORD);
    wire [1:0] nidx = out_idx + 2'h1;

    // Timing indication: fixed type, length 8, no sub-messages, reserved word
    assign tim_hdr.gen.id           = `ID_TTI_TIMING_IND;
    assign tim_hdr.gen.ref_num      = tim_ref;
    assign tim_hdr.gen.instance_num = `INSTANCE_ID;
    assign tim_hdr.gen.body_len     = `TIMING_BODY_LEN;
    assign tim_hdr.sub.sfn          = {6'h00, tim_sfn};
    assign tim_hdr.sub.tti          = {4'h0, tim_tti};
    assign tim_hdr.sub.sub_count    = 8'h00;
    assign tim_hdr.sub.confirm_mode = `CONFIRM_NONE;
    assign tim_hdr.sub.reserved     = `RSV24;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tim_pend  <= 1'b0;
            tim_sfn   <= '0;
            tim_tti   <= '0;
            tim_ref   <= '0;
            cnf_pend  <= 1'b0;
            req_ready <= 1'b1;
            cnf_hdr   <= '0;
            cnf_total <= '0;
        end else begin
            tim_pend <= tti_start || (tim_pend && !start_tim);
            if (tti_start) begin
                tim_sfn <= sfn;
                tim_tti <= tti;
            end
            if (start_tim) begin
                tim_ref <= tim_ref + 16'h0001;
            end
            cnf_pend  <= next_cnf_pend;
            req_ready <= !next_cnf_pend;
            if (cnf_set) begin
                cnf_hdr.gen.id           <= {req_id[15:10], `CLASS_CNF, req_id[7:0]};
                cnf_hdr.gen.ref_num      <= req_ref;
                cnf_hdr.gen.instance_num <= `INSTANCE_ID;
                cnf_hdr.gen.body_len     <= `CNF_BODY_LEN;
                cnf_hdr.sub.sfn          <= req_sfn;
                cnf_hdr.sub.tti          <= req_tti;
                cnf_hdr.sub.sub_count    <= 8'h00;
                cnf_hdr.sub.confirm_mode <= `CONFIRM_NONE;
                cnf_hdr.sub.reserved     <= `RSV24;
            end
            if (start_cnf) begin
                cnf_total <= cnf_total + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            out_idx   <= '0;
            out_hdr   <= '0;
            msg_data  <= '0;
            msg_valid <= 1'b0;
            msg_last  <= 1'b0;
        end else if (load) begin
            case (state)
                ST_IDLE: begin
                    out_idx  <= 2'h0;
                    msg_last <= 1'b0;
                    if (start_tim) begin
                        state     <= ST_TIM;
                        out_hdr   <= tim_hdr;
                        msg_data  <= hdr_word(tim_hdr, 2'h0);
                        msg_valid <= 1'b1;
                    end else if (start_cnf) begin
                        state     <= ST_CNF;
                        out_hdr   <= cnf_hdr;
                        msg_data  <= hdr_word(cnf_hdr, 2'h0);
                        msg_valid <= 1'b1;
                    end else begin
                        msg_valid <= 1'b0;
                    end
                end
                ST_TIM, ST_CNF: begin
                    if (out_end) begin
                        state     <= ST_IDLE;
                        msg_valid <= 1'b0;
                        msg_last  <= 1'b0;
                    end else begin
                        out_idx  <= nidx;
                        msg_data <= hdr_word(out_hdr, nidx);
                        msg_last <= (nidx == `LAST_WORD);
                    end
                end
                default: begin
                    state     <= ST_IDLE;
                    msg_valid <= 1'b0;
                end
            endcase
        end
    end

    sequence s_write_pair;
        aw_held && w_held && !s_axi_bvalid;
    endsequence
    sequence s_write_answer;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    property p_axi_write;
        @(posedge core_clk) disable iff (!rst_n) s_write_pair |=> s_write_answer;
    endproperty
    a_axi_write: assert property (p_axi_write) else $error("write answer missing");

    property p_tim_word0;
        @(posedge core_clk) disable iff (!rst_n)
            msg_valid && (state == ST_TIM) && (out_idx == 2'h0) |-> msg_data == {`ID_TTI_TIMING_IND, tim_ref - 16'h0001};
    endproperty
    a_tim_word0: assert property (p_tim_word0) else $error("timing word 0 wrong");

    property p_tim_word1;
        @(posedge core_clk) disable iff (!rst_n)
            msg_valid && (state == ST_TIM) && (out_idx == 2'h1) |-> msg_data == {`INSTANCE_ID, `TIMING_BODY_LEN};
    endproperty
    a_tim_word1: assert property (p_tim_word1) else $error("timing word 1 wrong");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!rst_n)
            msg_valid && (out_idx == `LAST_WORD) |-> msg_last && (msg_data[23:0] == `RSV24);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved field not zero");

    property p_cnf_pair;
        @(posedge core_clk) disable iff (!rst_n)
            cnf_set |=> (cnf_hdr.gen.ref_num == $past(req_ref)) && (cnf_hdr.gen.id.msg_class == `CLASS_CNF);
    endproperty
    a_cnf_pair: assert property (p_cnf_pair) else $error("confirm reference mismatch");

    property p_no_cnf;
        @(posedge core_clk) disable iff (!rst_n)
            in_beat && req_last && (cm_now == `CONFIRM_NONE) && !cnf_pend |=> !cnf_pend;
    endproperty
    a_no_cnf: assert property (p_no_cnf) else $error("confirm sent without request");

    property p_tim_ref;
        @(posedge core_clk) disable iff (!rst_n) start_tim |=> tim_ref == $past(tim_ref) + 16'h0001;
    endproperty
    a_tim_ref: assert property (p_tim_ref) else $error("reference counter did not step");

    property p_tim_pend;
        @(posedge core_clk) disable iff (!rst_n) tti_start |=> tim_pend && (tim_sfn == $past(sfn));
    endproperty
    a_tim_pend: assert property (p_tim_pend) else $error("tti tick lost");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_n) msg_valid && !msg_ready |=> msg_valid && $stable(msg_data);
    endproperty
    a_hold: assert property (p_hold) else $error("output dropped under stall");

endmodule : phy_sap_message_framer

// [rtl/phy_sap_params.svh]
/*
 * Constants of the PHY SAP message framer: message identifiers, header
 * field values, register map and timing.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef PHY_SAP_PARAMS_SVH
`define PHY_SAP_PARAMS_SVH

`define ID_TTI_TIMING_IND       16'h4001
`define ID_DL_SHARED_RX_IND     16'h4801
`define ID_UL_SHARED_RX_IND     16'h4401
`define ID_DL_TX_CONFIG_REQ     16'h4501
`define ID_DL_TX_CONFIG_CNF     16'h4601
`define ID_DL_TX_PAYLOAD_REQ    16'h4502
`define ID_DL_TX_PAYLOAD_CNF    16'h4602
`define ID_UL_TX_PAYLOAD_REQ    16'h4902
`define ID_UL_TX_PAYLOAD_CNF    16'h4a02

`define CLASS_IND               2'h0
`define CLASS_REQ               2'h1
`define CLASS_CNF               2'h2
`define CONFIRM_NONE            8'h00
`define CONFIRM_STD             8'h01
`define INSTANCE_ID             8'h00
`define TIMING_BODY_LEN         24'h000008
`define CNF_BODY_LEN            24'h000000
`define RSV24                   24'h000000

`define SFN_MAX                 10'h3ff
`define TTI_MAX                 4'h9
`define MSG_WORDS               3'h4
`define LAST_WORD               2'h3

`define CLK_FREQ_MHZ            200
`define TTI_TIME_US             1000

`define REG_CTRL                4'h0
`define REG_STATUS              4'h4
`define REG_COUNT               4'h8
`define CTRL_ENABLE             0
`define CTRL_TERMINAL           1
`define CTRL_RESET              2'h0
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// [rtl/phy_sap_pkg.sv]
/*
 * Types of the PHY SAP message framer: identifier layout, general header,
 * sub-header and output state.
 * Assumes the constants header is on the include path.
 */
package phy_sap_pkg;

    typedef struct packed {
        logic [1:0] iface;
        logic [1:0] layer;
        logic [1:0] scope;
        logic [1:0] msg_class;
        logic [7:0] number;
    } msg_id_t;

    typedef struct packed {
        msg_id_t     id;
        logic [15:0] ref_num;
        logic [7:0]  instance_num;
        logic [23:0] body_len;
    } gen_hdr_t;

    typedef struct packed {
        logic [15:0] sfn;
        logic [7:0]  tti;
        logic [7:0]  sub_count;
        logic [7:0]  confirm_mode;
        logic [23:0] reserved;
    } sub_hdr_t;

    typedef struct packed {
        gen_hdr_t gen;
        sub_hdr_t sub;
    } msg_hdr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TIM  = 3'b010,
        ST_CNF  = 3'b100
    } out_state_t;

endpackage : phy_sap_pkg

// [rtl/tti_timer.sv]
/*
 * TTI timer: TTI tick that counts only while run is high, with frame number and TTI index.
 * Assumes run and resync come from logic on core_clk.
 */
`include "phy_sap_params.svh"

module tti_timer #(
    parameter int TTI_CYCLES = `TTI_TIME_US * `CLK_FREQ_MHZ
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       resync,
    output logic            tti_start,
    output logic [9:0]      sfn,
    output logic [3:0]      tti
);
    localparam int CW = $clog2(TTI_CYCLES);
    localparam logic [CW-1:0] CYC_LAST = CW'(TTI_CYCLES - 1);

    logic [CW-1:0] cyc;
    wire           wrap     = run && (cyc == CYC_LAST);
    wire           tti_wrap = (tti == `TTI_MAX);

    // Internal counter; the resync input from outside clears it to zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc <= '0;
            sfn <= '0;
            tti <= '0;
        end else if (resync) begin
            cyc <= '0;
            sfn <= '0;
            tti <= '0;
        end else if (wrap) begin
            cyc <= '0;
            tti <= tti_wrap ? 4'h0 : tti + 4'h1;
            sfn <= (tti_wrap) ? ((sfn == `SFN_MAX) ? 10'h000 : sfn + 10'h001) : sfn;
        end else if (run) begin
            cyc <= cyc + CW'(1);
        end
    end

    assign tti_start = run && !resync && (cyc == '0);

    property p_sfn_range;
        @(posedge core_clk) disable iff (!rst_n) sfn <= `SFN_MAX;
    endproperty
    a_sfn_range: assert property (p_sfn_range) else $error("frame number out of range");

    property p_tti_range;
        @(posedge core_clk) disable iff (!rst_n) tti <= `TTI_MAX;
    endproperty
    a_tti_range: assert property (p_tti_range) else $error("tti index out of range");

    property p_resync;
        @(posedge core_clk) disable iff (!rst_n) resync |=> (sfn == 10'h000) && (tti == 4'h0) && (cyc == '0);
    endproperty
    a_resync: assert property (p_resync) else $error("resync did not clear counters");

    property p_tti_advance;
        @(posedge core_clk) disable iff (!rst_n)
            wrap && !resync |=> (tti == (($past(tti) == `TTI_MAX) ? 4'h0 : $past(tti) + 4'h1)) && (tti_start || !run);
    endproperty
    a_tti_advance: assert property (p_tti_advance) else $error("tti did not advance");

endmodule : tti_timer

// [verif/mac_model.sv]
/* MAC-side partner: sends request messages and sinks PHY messages.
   Assumes the framer's request and message streams on core_clk. */
module mac_model (
    input  wire logic        core_clk,
    input  wire logic        slow,
    input  wire logic        req_ready,
    output logic [31:0]      req_data,
    output logic             req_valid,
    output logic             req_last,
    output logic             msg_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] tick = 4'h0;
    initial req_data = 32'h0;
    initial req_valid = 1'b0;
    initial req_last = 1'b0;
    always @(posedge core_clk) tick <= tick + 4'h1;
    assign msg_ready = !slow || tick[1];
    task automatic send(input logic [15:0] id, input logic [15:0] rf, input logic [7:0] cm);
        logic [31:0] w [4];
        w = '{{id, rf}, 32'h0, 32'h00050300, {cm, 24'h0}};
        for (int i = 0; i < 4; i++) begin
            req_data <= w[i];
            req_valid <= 1'b1;
            req_last <= (i == 3);
            do @(negedge core_clk); while (req_ready !== 1'b1);
            @(posedge core_clk);
        end
        req_valid <= 1'b0;
        req_last <= 1'b0;
        req_data <= ~w[3];
        @(posedge core_clk);
    endtask : send
endmodule : mac_model

// [verif/phy_sap_message_framer_bench.sv]
/* Bench of the message framer: AXI4-Lite register tasks, MAC model, stream checks.
   Assumes the design package compiled first and a short TTI parameter. */
module phy_sap_message_framer_bench;
    import phy_sap_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TTI = 50;
    logic core_clk = 0, rst_n = 0, slow = 0, dl_sync_ok = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, d;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, req_ready, req_valid, req_last, msg_valid, msg_last, msg_ready;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, msg_data, req_data;
    int n_errors = 0, checked = 0, cyc = 0, sfn = 0, tti = 0, ncnf = 0;
    logic [15:0] tref = 0;
    logic [32:0] q[$], m[4];
    always #2.5 core_clk = ~core_clk;
    mac_model i_mac (.core_clk(core_clk), .slow(slow), .req_ready(req_ready), .req_data(req_data),
        .req_valid(req_valid), .req_last(req_last), .msg_ready(msg_ready));
    phy_sap_message_framer #(.TTI_CYCLES(TTI)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .req_data(req_data), .req_valid(req_valid), .req_last(req_last),
        .req_ready(req_ready), .msg_data(msg_data), .msg_valid(msg_valid), .msg_last(msg_last),
        .msg_ready(msg_ready), .dl_sync_ok(dl_sync_ok));
    always @(posedge core_clk) if (msg_valid === 1'b1 && msg_ready === 1'b1) q.push_back({msg_last, msg_data});
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        fork
            begin do @(negedge core_clk); while (awready !== 1'b1); @(posedge core_clk); awvalid <= 1'b0; end
            begin do @(negedge core_clk); while (wready !== 1'b1); @(posedge core_clk); wvalid <= 1'b0; end
        join
        do @(negedge core_clk); while (bvalid !== 1'b1);
        chk(bresp, er);
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge core_clk); while (arready !== 1'b1);
        @(posedge core_clk);
        arvalid <= 1'b0;
        do @(negedge core_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge core_clk);
    endtask : rd
    task automatic pop();
        for (int i = 0; i < 4; i++) begin
            while (q.size() == 0) @(posedge core_clk);
            m[i] = q.pop_front();
        end
    endtask : pop
    task automatic tim_chk();
        chk(m[0], {1'b0, 16'h4001, tref});
        chk(m[1], 33'h000000008);
        chk(m[2], {1'b0, 16'(sfn), 8'(tti), 8'h00});
        chk(m[3], 33'h100000000);
        tref++;
        sfn = m[2][31:16];
        tti = (m[2][15:8] == 9) ? 0 : m[2][15:8] + 1;
        if (tti == 0) sfn = (sfn + 1) % 1024;
    endtask : tim_chk
    task automatic resync();
        dl_sync_ok <= 1'b0;
        repeat (3 * TTI) @(posedge core_clk);
        while (q.size() >= 4) begin pop(); tim_chk(); end
        chk(q.size(), 0);
        sfn = 0;
        tti = 0;
        dl_sync_ok <= 1'b1;
        repeat (3) begin pop(); tim_chk(); end
    endtask : resync
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial begin
        logic [15:0] rq [3] = '{16'h4501, 16'h4502, 16'h4902};
        logic [15:0] cf [3] = '{16'h4601, 16'h4602, 16'h4a02};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(4'h0);
        chk(d, 0);
        wr(4'h0, 32'h1, 2'h0);
        repeat (12) begin pop(); tim_chk(); end
        $display("test timing done");
        slow <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            i_mac.send(16'h4801, 16'h0100, 8'h01);
            i_mac.send(rq[i], 16'h0200, 8'h00);
            i_mac.send(rq[i], 16'h1230 + 16'(i), 8'h01);
            pop();
            while (m[0][31:16] === 16'h4001) begin tim_chk(); pop(); end
            chk(m[0], {1'b0, cf[i], 16'h1230 + 16'(i)});
            chk(m[1], 33'h0);
            chk(m[2], 33'h000050300);
            chk(m[3], 33'h100000000);
            ncnf++;
        end
        slow <= 1'b0;
        $display("test confirm done");
        wr(4'h0, 32'h3, 2'h0);
        resync();
        resync();
        dl_sync_ok <= 1'b0;
        repeat (3 * TTI) @(posedge core_clk);
        while (q.size() >= 4) begin pop(); tim_chk(); end
        wr(4'h8, 32'hffffffff, 2'h0);
        rd(4'h8);
        chk({r, d}, {2'h0, tref, 16'(ncnf)});
        wr(4'hc, 32'h1, 2'h2);
        rd(4'hc);
        chk({r, d}, {2'h2, 32'h0});
        $display("test registers done");
        tally_and_finish();
    end
endmodule : phy_sap_message_framer_bench
